// >>> oslmc_checker.sv
// port assertions for the display line and memory write control block
`timescale 1ns/10ps
module oslmc_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [3:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic verticalSyncN,
  input wire logic horizontalSyncN,
  input wire logic irqPulse,
  input wire logic memWrCode,
  input wire logic memWrAttr,
  input wire logic [8:0] memWrAddr,
  input wire logic [7:0] memCode,
  input wire logic [5:0] memAttr,
  input wire logic dispEnable,
  input wire logic blinkMaster
);
  logic vPrev;
  logic hPrev;
  logic [2:0] sinceV;
  logic [2:0] sinceH;
  logic wrCode;
  logic wrAttr;
  // ******************************
  // ages of the last sync falls, saturating so they never wrap back into range
  // ******************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      vPrev <= 1'b1;
      hPrev <= 1'b1;
      sinceV <= 3'h7;
      sinceH <= 3'h7;
    end else begin
      vPrev <= verticalSyncN;
      hPrev <= horizontalSyncN;
      sinceV <= (vPrev && !verticalSyncN) ? 3'h0 : sinceV + {2'h0, sinceV != 3'h7};
      sinceH <= (hPrev && !horizontalSyncN) ? 3'h0 : sinceH + {2'h0, sinceH != 3'h7};
    end
  end
  assign wrCode = regWr && regAddr == oslmc_pkg::REG_CHAR;
  assign wrAttr = regWr && regAddr == oslmc_pkg::REG_ATTR;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_irq_one; irqPulse |=> !irqPulse; endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq pulse too long");
  property p_irq_cause; irqPulse |-> (sinceV < 3'h4 || sinceH < 3'h4); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without sync fall");
  property p_code; wrCode |=> memWrCode && memCode == $past(regWdata); endproperty
  a_code: assert property (p_code) else $error("code write lost");
  property p_attr; wrAttr |=> memWrAttr && memAttr == $past(regWdata[5:0]); endproperty
  a_attr: assert property (p_attr) else $error("attribute write lost");
  property p_no_wr; !(wrCode || wrAttr) |=> !memWrCode && !memWrAttr; endproperty
  a_no_wr: assert property (p_no_wr) else $error("spurious memory write");
  property p_addr_hold; $changed(memWrAddr) |-> memWrCode || memWrAttr; endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved alone");
  property p_rd_idle; !regRd |=> regRdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_rd_unmapped; regRd && regAddr[3] |=> regRdata == 8'h00; endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_xfer; $changed(dispEnable) |-> sinceH < 3'h3; endproperty
  a_xfer: assert property (p_xfer) else $error("transfer off sync fall");
  property p_blink; regWr && regAddr == oslmc_pkg::REG_MISC |=> blinkMaster == $past(regWdata[6]); endproperty
  a_blink: assert property (p_blink) else $error("immediate bit not taken");
  c_code: cover property (memWrCode && memWrAttr);
  c_irq: cover property (irqPulse);
  c_xfer: cover property ($rose(dispEnable));
endmodule
bind oslmc_line_ctrl oslmc_checker i_chk (.core_clk, .rstn, .regAddr, .regWr, .regRd, .regWdata, .regRdata,
  .verticalSyncN, .horizontalSyncN, .irqPulse, .memWrCode, .memWrAttr, .memWrAddr, .memCode, .memAttr,
  .dispEnable, .blinkMaster);

// >>> oslmc_cpu_model.sv
// core-side register master driving the direct bank register port
`timescale 1ns/10ps
module oslmc_cpu_model (
  input wire logic core_clk,
  output logic [3:0] regAddr,
  output logic regWr,
  output logic regRd,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial begin
    regAddr = 4'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    regWdata = 8'h00;
  end
  // single byte per access, never a two-byte transfer
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #2;
    regAddr = a;
    regWdata = d;
    regWr = 1'b1;
    @(posedge core_clk);
    #2;
    regWr = 1'b0;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #2;
    regAddr = a;
    regRd = 1'b1;
    @(posedge core_clk);
    #2;
    regRd = 1'b0;
    d = regRdata;
  endtask
  // low byte first, then the high bit, every time
  task automatic memAddr(input logic [8:0] ad, input logic bank);
    wr(oslmc_pkg::REG_ADDR_LOW, ad[7:0]);
    wr(oslmc_pkg::REG_MISC, {6'h00, bank, ad[8]});
  endtask
  // spacing keeps the memory path clear between writes
  task automatic memWr(input logic [3:0] a, input logic [7:0] d);
    wr(a, d);
    repeat (3) @(posedge core_clk);
  endtask
  // request bit only ever written as 1, polled after a gap
  task automatic xferReq(input logic [1:0] en);
    wr(oslmc_pkg::REG_ON_XFER, {5'h00, 1'b1, en});
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// >>> oslmc_line_ctrl.sv
// display line counter, line interrupt, pin routing, memory write path and buffered register transfer
`timescale 1ns/10ps
module oslmc_line_ctrl (
  input wire logic core_clk,
  input wire logic rstn,
  // register port of the direct bank space
  input wire logic [3:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // sync inputs, active low
  input wire logic verticalSyncN,
  input wire logic horizontalSyncN,
  // scan position from the character renderer
  input wire logic lineActive,
  input wire logic lastScan,
  input wire logic pageArea,
  input wire logic charArea,
  input wire logic blankCode,
  // pixel data from the renderer
  input wire logic redPix,
  input wire logic greenPix,
  input wire logic bluePix,
  input wire logic fringePix,
  // ordinary port latch for the four shared pins
  input wire logic [3:0] portLatch,
  output logic [3:0] pinOut,
  output logic irqPulse,
  // display memory write port
  output logic memWrCode,
  output logic memWrAttr,
  output logic [8:0] memWrAddr,
  output logic [7:0] memCode,
  output logic [5:0] memAttr,
  // active copies of buffered and immediate settings
  output logic dispEnable,
  output logic windowEnable,
  output logic blinkMaster,
  output logic revBlinkMaster,
  output logic smoothEnable
);
  // ****************************************
  // reset release
  // ****************************************
  logic rstSync1_q;
  logic rstSync2_q;
  // the copy rises two edges after the pin, so no flop leaves reset on an edge racing the pin
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  // ****************************************
  // state
  // ****************************************
  oslmc_pkg::oslmc_state_t st_q;
  oslmc_pkg::oslmc_state_t st_d;

  logic vsyncFall;
  logic hsyncFall;
  logic lineEnd;
  logic xferNow;
  logic [3:0] lineNext;
  logic lumaSig;
  logic blankSig;
  logic lumaBlankSig;
  logic lumaBlankInv;
  logic [3:0] pinNext;
  logic wrLineIrq;
  logic wrPinSel;
  logic wrMisc;
  logic wrAddrLow;
  logic wrOnXfer;
  logic wrAttr;
  logic wrChar;
  logic wrBlank;

  // ****************************************
  // pin signals
  // ****************************************
  // kept outside the state process so the pin groups never loop back into it
  assign lumaSig = redPix | greenPix | bluePix | fringePix;
  assign blankSig = st_q.fullBlankAct ? pageArea : (charArea && !blankCode);
  assign lumaBlankSig = st_q.lumaBlankSel ? blankSig : lumaSig;
  // the shared pin follows the polarity bit of whichever signal it carries
  assign lumaBlankInv = st_q.lumaBlankSel ? st_q.polAct[2] : st_q.polAct[1];

  // the three colour pins share one polarity bit
  oslmc_pin_group #(
    .W(oslmc_pkg::PIN_W - 1)
  ) i_colourPins (
    .dispSig({redPix, greenPix, bluePix}),
    .invert(st_q.polAct[0]),
    .sel(st_q.pinSel[oslmc_pkg::PIN_W-1:1]),
    .latch(portLatch[oslmc_pkg::PIN_W-1:1]),
    .pinLevel(pinNext[oslmc_pkg::PIN_W-1:1])
  );

  oslmc_pin_group #(
    .W(1)
  ) i_lumaBlankPin (
    .dispSig(lumaBlankSig),
    .invert(lumaBlankInv),
    .sel(st_q.pinSel[0]),
    .latch(portLatch[0]),
    .pinLevel(pinNext[0])
  );

  always_comb begin
    st_d = st_q;
    // ****************************************
    // sync edges
    // ****************************************
    st_d.vsyncPrev = verticalSyncN;
    st_d.hsyncPrev = horizontalSyncN;
    vsyncFall = st_q.vsyncPrev && !verticalSyncN;
    hsyncFall = st_q.hsyncPrev && !horizontalSyncN;
    lineEnd = hsyncFall && lineActive && lastScan;
    // a horizontal sync fall inside a line but not on its last scan leaves the count alone

    // decode of register writes
    wrLineIrq = regWr && (regAddr == oslmc_pkg::REG_LINE_IRQ);
    wrPinSel = regWr && (regAddr == oslmc_pkg::REG_PIN_SEL);
    wrMisc = regWr && (regAddr == oslmc_pkg::REG_MISC);
    wrAddrLow = regWr && (regAddr == oslmc_pkg::REG_ADDR_LOW);
    wrOnXfer = regWr && (regAddr == oslmc_pkg::REG_ON_XFER);
    wrAttr = regWr && (regAddr == oslmc_pkg::REG_ATTR);
    wrChar = regWr && (regAddr == oslmc_pkg::REG_CHAR);
    wrBlank = regWr && (regAddr == oslmc_pkg::REG_BLANK);

    // ****************************************
    // line counter and interrupt
    // ****************************************
    // the counter wraps after 15; more lines than that are not expected on a page
    lineNext = st_q.lineCount + oslmc_pkg::LINE_ONE;
    st_d.irqPulse = 1'b0;
    if (vsyncFall) begin
      st_d.lineCount = oslmc_pkg::LINE_ZERO;
    end else if (lineEnd) begin
      st_d.lineCount = lineNext;
    end
    if (st_q.srcSelAct) begin
      st_d.irqPulse = vsyncFall;
    end else if (st_q.lineSetAct == oslmc_pkg::LINE_ZERO) begin
      st_d.irqPulse = vsyncFall;
    end else begin
      // a page restart in the same cycle as a line end drops the match
      st_d.irqPulse = lineEnd && !vsyncFall && (lineNext == st_q.lineSetAct);
    end

    // ****************************************
    // buffered registers and transfer
    // ****************************************
    // the line interrupt byte is held whole, the others only in their defined bits; writes while pending are
    // accepted as written, so software must respect the busy bit
    if (wrLineIrq) begin
      st_d.polBuf = regWdata[oslmc_pkg::BLANK_POL_BIT:oslmc_pkg::COLOUR_POL_BIT];
      st_d.srcSelBuf = regWdata[oslmc_pkg::SRC_SEL_BIT];
      st_d.lineSetBuf = regWdata[oslmc_pkg::LINE_LSB +: oslmc_pkg::LINE_W];
    end
    if (wrBlank) begin
      st_d.fullBlankBuf = regWdata[oslmc_pkg::FULL_BLANK_BIT];
    end
    if (wrOnXfer) begin
      st_d.dispEnBuf = regWdata[oslmc_pkg::DISP_EN_BIT];
      st_d.windowEnBuf = regWdata[oslmc_pkg::WINDOW_EN_BIT];
    end
    // outside a display line any horizontal sync fall ends a blank line; inside, only the last scan
    xferNow = st_q.xferPending && hsyncFall && (!lineActive || lastScan);
    // all buffered fields move together so the display never sees a half-updated setting
    if (xferNow) begin
      st_d.polAct = st_q.polBuf;
      st_d.srcSelAct = st_q.srcSelBuf;
      st_d.lineSetAct = st_q.lineSetBuf;
      st_d.fullBlankAct = st_q.fullBlankBuf;
      st_d.dispEnAct = st_q.dispEnBuf;
      st_d.windowEnAct = st_q.windowEnBuf;
      st_d.xferPending = 1'b0;
    end
    // a new request in the completing cycle wins, so it is never lost
    if (wrOnXfer && regWdata[oslmc_pkg::XFER_REQ_BIT]) begin
      st_d.xferPending = 1'b1;
    end

    // ****************************************
    // immediate registers
    // ****************************************
    if (wrPinSel) begin
      st_d.pinSel = regWdata[oslmc_pkg::PIN_SEL_LSB +: oslmc_pkg::PIN_W];
    end
    if (wrMisc) begin
      st_d.lumaBlankSel = regWdata[oslmc_pkg::LUMA_BLANK_SEL_BIT];
      st_d.blinkMaster = regWdata[oslmc_pkg::BLINK_MASTER_BIT];
      st_d.revBlinkMaster = regWdata[oslmc_pkg::REV_BLINK_MASTER_BIT];
      st_d.smoothEn = regWdata[oslmc_pkg::SMOOTH_BIT];
      st_d.bankMode = regWdata[oslmc_pkg::BANK_MODE_BIT];
      st_d.memAddr[oslmc_pkg::ADDR_W-1] = regWdata[oslmc_pkg::ADDR_HIGH_BIT];
    end
    // a high-bit write leaves the low byte as it is; software writes both halves every time
    if (wrAddrLow) begin
      st_d.memAddr[oslmc_pkg::ADDR_W-2:0] = regWdata;
    end

    // ****************************************
    // display memory writes
    // ****************************************
    st_d.memWrCode = 1'b0;
    st_d.memWrAttr = 1'b0;
    // only one register index is decoded per cycle; the two strobes meet only on a character write in bank mode
    if (wrAttr) begin
      st_d.attrHold = regWdata[oslmc_pkg::ATTR_W-1:0];
      st_d.memAttr = regWdata[oslmc_pkg::ATTR_W-1:0];
      st_d.memWrAttr = 1'b1;
      st_d.memWrAddr = st_q.memAddr;
      if (!st_q.bankMode) begin
        st_d.memAddr = st_q.memAddr + oslmc_pkg::ADDR_ONE;
      end
    end else if (wrChar) begin
      st_d.memCode = regWdata;
      st_d.memWrCode = 1'b1;
      st_d.memWrAddr = st_q.memAddr;
      if (st_q.bankMode) begin
        st_d.memAttr = st_q.attrHold;
        st_d.memWrAttr = 1'b1;
      end
      st_d.memAddr = st_q.memAddr + oslmc_pkg::ADDR_ONE;
    end

    // ****************************************
    // pin outputs
    // ****************************************
    // registered here so the pins change only on the clock
    st_d.pinOut = pinNext;

    // ****************************************
    // register reads
    // ****************************************
    // read data lasts one cycle and idles at zero, so a stray strobe shows nothing stale
    st_d.rdData = oslmc_pkg::BYTE_ZERO;
    if (regRd) begin
      case (regAddr)
        oslmc_pkg::REG_LINE_IRQ: begin
          st_d.rdData = {st_q.polBuf, st_q.srcSelBuf, st_q.lineCount};
        end
        oslmc_pkg::REG_PIN_SEL: begin
          st_d.rdData = {st_q.pinSel, oslmc_pkg::NIBBLE_ZERO};
        end
        oslmc_pkg::REG_MISC: begin
          st_d.rdData = {st_q.lumaBlankSel, st_q.blinkMaster, st_q.revBlinkMaster, st_q.smoothEn,
                         2'h0, st_q.bankMode, st_q.memAddr[oslmc_pkg::ADDR_W-1]};
        end
        oslmc_pkg::REG_ADDR_LOW: begin
          st_d.rdData = st_q.memAddr[oslmc_pkg::ADDR_W-2:0];
        end
        oslmc_pkg::REG_ON_XFER: begin
          st_d.rdData = {5'h00, st_q.xferPending, st_q.windowEnBuf, st_q.dispEnBuf};
        end
        oslmc_pkg::REG_BLANK: begin
          st_d.rdData = {1'b0, st_q.fullBlankBuf, 6'h00};
        end
        default: begin
          st_d.rdData = oslmc_pkg::BYTE_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstSync2_q) begin
    if (!rstSync2_q) begin
      st_q <= '0;
      st_q.vsyncPrev <= 1'b1;
      st_q.hsyncPrev <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // every output is a field of the registered state
  assign regRdata = st_q.rdData;
  assign pinOut = st_q.pinOut;
  assign irqPulse = st_q.irqPulse;
  assign memWrCode = st_q.memWrCode;
  assign memWrAttr = st_q.memWrAttr;
  assign memWrAddr = st_q.memWrAddr;
  assign memCode = st_q.memCode;
  assign memAttr = st_q.memAttr;
  assign dispEnable = st_q.dispEnAct;
  assign windowEnable = st_q.windowEnAct;
  assign blinkMaster = st_q.blinkMaster;
  assign revBlinkMaster = st_q.revBlinkMaster;
  assign smoothEnable = st_q.smoothEn;
endmodule

// one group of shared pins: display signals with their polarity, or the port latch
module oslmc_pin_group #(
  parameter int W = 1
) (
  input wire logic [W-1:0] dispSig,
  input wire logic invert,
  input wire logic [W-1:0] sel,
  input wire logic [W-1:0] latch,
  output logic [W-1:0] pinLevel
);
  // a deselected pin shows the port latch unchanged, whatever the polarity setting
  assign pinLevel = (sel & (dispSig ^ {W{invert}})) | (~sel & latch);
endmodule

// >>> oslmc_pkg.sv
// constants, register map and state type of the display line / memory write control block
package oslmc_pkg;
  // ****************************************
  // register indices on the internal register port
  // ****************************************
  localparam logic [3:0] REG_LINE_IRQ = 4'h0;
  localparam logic [3:0] REG_PIN_SEL = 4'h1;
  localparam logic [3:0] REG_MISC = 4'h2;
  localparam logic [3:0] REG_ADDR_LOW = 4'h3;
  localparam logic [3:0] REG_ON_XFER = 4'h4;
  localparam logic [3:0] REG_ATTR = 4'h5;
  localparam logic [3:0] REG_CHAR = 4'h6;
  localparam logic [3:0] REG_BLANK = 4'h7;
  // ****************************************
  // field positions
  // ****************************************
  localparam int LINE_LSB = 0;
  localparam int SRC_SEL_BIT = 4;
  localparam int COLOUR_POL_BIT = 5;
  localparam int LUMA_POL_BIT = 6;
  localparam int BLANK_POL_BIT = 7;
  localparam int PIN_SEL_LSB = 4;
  localparam int ADDR_HIGH_BIT = 0;
  localparam int BANK_MODE_BIT = 1;
  localparam int SMOOTH_BIT = 4;
  localparam int REV_BLINK_MASTER_BIT = 5;
  localparam int BLINK_MASTER_BIT = 6;
  localparam int LUMA_BLANK_SEL_BIT = 7;
  localparam int DISP_EN_BIT = 0;
  localparam int WINDOW_EN_BIT = 1;
  localparam int XFER_REQ_BIT = 2;
  localparam int FULL_BLANK_BIT = 6;
  localparam int ATTR_W = 6;
  localparam int ADDR_W = 9;
  localparam int LINE_W = 4;
  localparam int PIN_W = 4;
  // ****************************************
  // zero and increment constants
  // ****************************************
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [3:0] LINE_ZERO = 4'h0;
  localparam logic [3:0] LINE_ONE = 4'h1;
  localparam logic [8:0] ADDR_ZERO = 9'h000;
  localparam logic [8:0] ADDR_ONE = 9'h001;
  localparam logic [5:0] ATTR_ZERO = 6'h00;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  typedef struct packed {
    logic vsyncPrev;
    logic hsyncPrev;
    logic [3:0] lineCount;
    // buffered copies written by software
    logic [2:0] polBuf;
    logic srcSelBuf;
    logic [3:0] lineSetBuf;
    logic fullBlankBuf;
    logic dispEnBuf;
    logic windowEnBuf;
    // active copies used by the display logic, then the pending transfer flag
    logic [2:0] polAct;
    logic srcSelAct;
    logic [3:0] lineSetAct;
    logic fullBlankAct;
    logic dispEnAct;
    logic windowEnAct;
    logic xferPending;
    // registers that take effect at once
    logic [3:0] pinSel;
    logic lumaBlankSel;
    logic blinkMaster;
    logic revBlinkMaster;
    logic smoothEn;
    logic bankMode;
    logic [8:0] memAddr;
    logic [5:0] attrHold;
    // outputs
    logic [3:0] pinOut;
    logic irqPulse;
    logic [7:0] rdData;
    logic memWrCode;
    logic memWrAttr;
    logic [7:0] memCode;
    logic [5:0] memAttr;
    logic [8:0] memWrAddr;
  } oslmc_state_t;
endpackage

// >>> tb_top.sv
// self-checking bench for the display line and memory write control block
`timescale 1ns/10ps
module tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] regAddr;
  logic regWr;
  logic regRd;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic verticalSyncN = 1'b1;
  logic horizontalSyncN = 1'b1;
  logic lineActive = 1'b0;
  logic lastScan = 1'b0;
  logic pageArea = 1'b0;
  logic charArea = 1'b0;
  logic blankCode = 1'b0;
  logic redPix = 1'b0;
  logic greenPix = 1'b0;
  logic bluePix = 1'b0;
  logic fringePix = 1'b0;
  logic [3:0] portLatch = 4'h0;
  logic [3:0] pinOut;
  logic irqPulse, memWrCode, memWrAttr, dispEnable, windowEnable, blinkMaster;
  logic revBlinkMaster;
  logic smoothEnable;
  logic [8:0] memWrAddr;
  logic [7:0] memCode;
  logic [5:0] memAttr;
  logic [8:0] wAddr;
  logic wCode;
  logic wAttr;
  logic [15:0] r = 16'hee80;
  logic [15:0] cfg;
  logic [7:0] d;
  logic [2:0] col;
  logic y;
  logic bl;
  int nMismatch = 0;
  int testsRun = 0;
  int nIrq = 0;
  int n0;
  // reference model of the display memory write path
  int mAddr = 0;
  int mBank = 0;
  int mCode = 0;
  int mAttr = 0;
  logic [24:0] expWr[$];
  oslmc_line_ctrl i_dut (.core_clk, .rstn, .regAddr, .regWr, .regRd, .regWdata, .regRdata, .verticalSyncN,
    .horizontalSyncN, .lineActive, .lastScan, .pageArea, .charArea, .blankCode, .redPix, .greenPix, .bluePix,
    .fringePix, .portLatch, .pinOut, .irqPulse, .memWrCode, .memWrAttr, .memWrAddr, .memCode, .memAttr,
    .dispEnable, .windowEnable, .blinkMaster, .revBlinkMaster, .smoothEnable);
  oslmc_cpu_model i_cpu (.core_clk, .regAddr, .regWr, .regRd, .regWdata, .regRdata);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (irqPulse === 1'b1) nIrq++;
    if (memWrCode === 1'b1 || memWrAttr === 1'b1) begin
      wAddr = memWrAddr;
      wCode = memWrCode;
      wAttr = memWrAttr;
      chk(expWr.size(), 1);
      if (expWr.size() > 0) chk({memWrCode, memWrAttr, memWrAddr, memCode, memAttr}, expWr.pop_front());
    end
  end
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tallyAndFinish;
    $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic syncFall(input logic v, input logic act, input logic last);
    @(posedge core_clk);
    #2;
    lineActive = act;
    lastScan = last;
    {verticalSyncN, horizontalSyncN} = {~v, v};
    repeat (2) @(posedge core_clk);
    #2;
    {verticalSyncN, horizontalSyncN} = 2'b11;
    repeat (2) @(posedge core_clk);
  endtask
  // stale capture cleared so a missing pulse shows as unknown
  task automatic mw(input logic [3:0] a, input logic [7:0] v);
    wCode = 1'bx;
    wAttr = 1'bx;
    wAddr = 9'hxxx;
    if (a == oslmc_pkg::REG_ATTR) begin
      mAttr = v[5:0];
      expWr.push_back({2'h1, 9'(mAddr), 8'(mCode), 6'(mAttr)});
      if (mBank == 0) mAddr = (mAddr + 1) % 512;
    end else begin
      mCode = v;
      expWr.push_back({1'b1, 1'(mBank), 9'(mAddr), 8'(mCode), 6'(mAttr)});
      mAddr = (mAddr + 1) % 512;
    end
    i_cpu.memWr(a, v);
  endtask
  initial begin
    #1ms;
    nMismatch++;
    tallyAndFinish();
  end
  // ******************************
  // main sequence
  // ******************************
  initial begin
    repeat (4) @(posedge core_clk);
    #2;
    rstn = 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 10; i++) begin
      i_cpu.rd(i[3:0], d);
      chk(d, 8'h00);
    end
    for (int i = 0; i < 12; i++) begin
      r = nxt(r);
      cfg = r;
      i_cpu.wr(oslmc_pkg::REG_LINE_IRQ, {cfg[7:4], 4'h0});
      i_cpu.wr(oslmc_pkg::REG_BLANK, {1'b0, cfg[8], 6'h00});
      i_cpu.wr(oslmc_pkg::REG_PIN_SEL, {cfg[12:9], 4'h0});
      i_cpu.wr(oslmc_pkg::REG_MISC, {cfg[13], cfg[14], cfg[15], cfg[3], 4'h0});
      chk(blinkMaster, cfg[14]);
      chk({revBlinkMaster, smoothEnable}, {cfg[15], cfg[3]});
      i_cpu.rd(oslmc_pkg::REG_MISC, d);
      chk(d, {cfg[13], cfg[14], cfg[15], cfg[3], 4'h0});
      i_cpu.rd(oslmc_pkg::REG_PIN_SEL, d);
      chk(d, {cfg[12:9], 4'h0});
      i_cpu.xferReq(cfg[1:0]);
      i_cpu.rd(oslmc_pkg::REG_ON_XFER, d);
      chk(d[2], 1'b1);
      syncFall(1'b0, 1'b1, 1'b0);
      i_cpu.rd(oslmc_pkg::REG_ON_XFER, d);
      chk(d[2], 1'b1);
      syncFall(1'b0, i[0], i[0]);
      i_cpu.rd(oslmc_pkg::REG_ON_XFER, d);
      chk(d[2], 1'b0);
      chk({windowEnable, dispEnable}, cfg[1:0]);
      repeat (6) begin
        r = nxt(r);
        @(posedge core_clk);
        #2;
        {redPix, greenPix, bluePix, fringePix, pageArea, charArea, blankCode, portLatch} = r[10:0];
        col = {redPix, greenPix, bluePix} ^ {3{cfg[5]}};
        y = (redPix | greenPix | bluePix | fringePix) ^ cfg[6];
        bl = (cfg[8] ? pageArea : (charArea & ~blankCode)) ^ cfg[7];
        repeat (3) @(posedge core_clk);
        #2;
        chk(pinOut, ({col, cfg[13] ? bl : y} & cfg[12:9]) | (portLatch & ~cfg[12:9]));
      end
    end
    for (int k = 0; k < 5; k++) begin
      i_cpu.wr(oslmc_pkg::REG_LINE_IRQ, (k == 4) ? 8'h10 : {4'h0, 4'(k * 5)});
      i_cpu.xferReq(2'b01);
      syncFall(1'b0, 1'b0, 1'b0);
      n0 = nIrq;
      syncFall(1'b1, 1'b0, 1'b0);
      i_cpu.rd(oslmc_pkg::REG_LINE_IRQ, d);
      chk(d[3:0], 4'h0);
      repeat (15) syncFall(1'b0, 1'b1, 1'b1);
      chk(nIrq - n0, 1);
      i_cpu.rd(oslmc_pkg::REG_LINE_IRQ, d);
      chk(d[3:0], 4'hf);
    end
    for (int k = 0; k < 2; k++) begin
      i_cpu.memAddr(9'h1ff, k[0]);
      mAddr = 511;
      mBank = k;
      r = nxt(r);
      mw(oslmc_pkg::REG_ATTR, r[7:0]);
      chk({wCode, wAttr, wAddr, memAttr}, {2'b01, 9'h1ff, r[5:0]});
      mw(oslmc_pkg::REG_CHAR, r[15:8]);
      chk({wCode, wAttr, wAddr, memCode}, {1'b1, k[0], k[0] ? 9'h1ff : 9'h000, r[15:8]});
      chk(memAttr, r[5:0]);
      mw(oslmc_pkg::REG_ATTR, r[7:0]);
      chk(wAddr, k[0] ? 9'h000 : 9'h001);
    end
    chk(expWr.size(), 0);
    tallyAndFinish();
  end
endmodule
